// File: design/rtcoc_pkg.sv
/*
 * Constants and types for the RTC offset-correction and oscillator-control block.
 * Assumes a 200 MHz system clock and a one-pulse-per-second tick from the timekeeping core.
 */
// ==========================================================================
// Operation
// - Fast mode starts correction every eight minutes.
// - One pulse per second, spilling into later minutes.
// - Oscillator register 13h bit layout fixed.
// - Invert bit inverts selected output, moves edge.
// - Mode bit: 0 four hours, 1 eight minutes.
// - Low-jitter bit reduces output jitter.
// - Drive field: normal, low, high, high.
// - Load field: 7.0, 6.0, 12.5, 12.5 pF.
// - Invert acts on frequency-selected clock output.
// - Correct by pulses, never oscillator frequency.
// - Offset value is two's complement, +127 to -128.
package rtcoc_pkg;
    localparam logic [7:0] OSC_CFG_ADDR   = 8'h13;
    localparam logic [7:0] OFFSET_ADDR    = 8'h12;
    localparam logic [7:0] OSC_CFG_RESET  = 8'h00;
    localparam logic [7:0] OSC_CFG_WMASK  = 8'hDF;
    localparam int         BIT_INVERT     = 7;
    localparam int         BIT_MODE       = 6;
    localparam int         BIT_LOW_JITTER_EN       = 4;
    localparam int         FAST_PERIOD_MIN   = 8;
    localparam int         NORMAL_PERIOD_HR  = 4;
    localparam int         NORMAL_PERIOD_MIN = NORMAL_PERIOD_HR * 60;
    localparam logic [7:0] FAST_PERIOD    = 8'h08;
    localparam logic [7:0] NORMAL_PERIOD  = 8'hF0;
    localparam logic [5:0] UNITS_PER_MIN  = 6'h3B;
    localparam logic [1:0] DRV_NORMAL     = 2'h0;
    localparam logic [1:0] DRV_LOW        = 2'h1;
    localparam logic [1:0] DRV_HIGH       = 2'h2;
    localparam logic [1:0] CAP_7P0        = 2'h0;
    localparam logic [1:0] CAP_6P0        = 2'h1;
    localparam logic [1:0] CAP_12P5       = 2'h2;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } rtcoc_wr_t;

    typedef struct packed {
        logic       clkout_invert;
        logic       correction_mode_sel;
        logic       rsvd;
        logic       low_jitter_en;
        logic [1:0] xtal_drive_sel;
        logic [1:0] xtal_load_cap_sel;
    } rtcoc_osc_t;

    typedef enum logic [2:0] {
        RTCOC_IDLE  = 3'h1,
        RTCOC_WAIT  = 3'h2,
        RTCOC_APPLY = 3'h4
    } rtcoc_state_t;
endpackage

// File: design/rtcoc_pulse_sched.sv
/*
 * Correction-pulse scheduler: counts correction periods and emits pulses.
 * Assumes sec_tick_i and min_tick_i are one-cycle pulses on clock_i.
 */
`timescale 1ns/1ps
module rtcoc_pulse_sched (
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    input  wire logic       fast_i,
    input  wire logic [7:0] offset_i,
    input  wire logic       sec_tick_i,
    input  wire logic       min_tick_i,
    output logic            pulse_add_o,
    output logic            pulse_sub_o,
    output logic            busy_o
);
    rtcoc_pkg::rtcoc_state_t state;
    rtcoc_pkg::rtcoc_state_t next_state;
    logic [7:0] min_cnt;
    logic [7:0] next_min_cnt;
    logic [7:0] remain;
    logic [7:0] next_remain;
    logic       neg;
    logic       next_neg;
    logic       next_add;
    logic       next_sub;
    logic [5:0] units;
    logic [5:0] next_units;
    logic       next_units_last;

    // ==========================================================================
    // Magnitude of a two's complement offset, -128 giving 128.
    function automatic logic [7:0] mag(input logic [7:0] v);
        mag = v[7] ? 8'(~v + 8'h01) : v;
    endfunction

    always_comb begin
        next_state   = state;
        next_min_cnt = min_cnt;
        next_remain  = remain;
        next_neg     = neg;
        next_add     = 1'b0;
        next_sub     = 1'b0;
        if (min_tick_i) begin
            next_min_cnt = 8'(min_cnt + 8'h01);
        end
        unique case (state)
            rtcoc_pkg::RTCOC_IDLE: begin
                if (min_tick_i && next_min_cnt >= (fast_i ? rtcoc_pkg::FAST_PERIOD
                                                          : rtcoc_pkg::NORMAL_PERIOD)) begin
                    next_min_cnt = 8'h00;
                    if (offset_i != 8'h00) begin
                        next_remain = mag(offset_i);
                        next_neg    = offset_i[7];
                        next_state  = rtcoc_pkg::RTCOC_APPLY;
                    end
                end
            end
            rtcoc_pkg::RTCOC_WAIT: begin
                // Spilling pulses resume at unit 00 of the next minute.
                if (min_tick_i) begin
                    next_state = rtcoc_pkg::RTCOC_APPLY;
                end
            end
            rtcoc_pkg::RTCOC_APPLY: begin
                // Fast mode steps once per second, normal mode once per minute.
                if (fast_i ? sec_tick_i : min_tick_i) begin
                    next_add    = ~neg;
                    next_sub    = neg;
                    next_remain = 8'(remain - 8'h01);
                    if (remain == 8'h01) begin
                        next_state = rtcoc_pkg::RTCOC_IDLE;
                    end else if (fast_i && next_units_last) begin
                        next_state = rtcoc_pkg::RTCOC_WAIT;
                    end
                end
            end
            default: next_state = rtcoc_pkg::RTCOC_IDLE;
        endcase
    end

    always_comb begin
        next_units      = units;
        next_units_last = (units == rtcoc_pkg::UNITS_PER_MIN);
        if (min_tick_i) begin
            next_units = 6'h00;
        end else if (sec_tick_i) begin
            next_units = next_units_last ? units : 6'(units + 6'h01);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state       <= rtcoc_pkg::RTCOC_IDLE;
            min_cnt     <= 8'h00;
            remain      <= 8'h00;
            neg         <= 1'b0;
            units       <= 6'h00;
            pulse_add_o <= 1'b0;
            pulse_sub_o <= 1'b0;
            busy_o      <= 1'b0;
        end else begin
            state       <= next_state;
            min_cnt     <= next_min_cnt;
            remain      <= next_remain;
            neg         <= next_neg;
            units       <= next_units;
            pulse_add_o <= next_add;
            pulse_sub_o <= next_sub;
            busy_o      <= (next_state != rtcoc_pkg::RTCOC_IDLE);
        end
    end

    AST_PULSE_EXCL: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !(pulse_add_o && pulse_sub_o)) else $error("add and sub pulse together");
    AST_PULSE_NEEDS_TICK: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (pulse_add_o || pulse_sub_o) |-> $past(fast_i ? sec_tick_i : min_tick_i))
        else $error("pulse without a time tick");
    AST_FAST_START: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (state == rtcoc_pkg::RTCOC_IDLE && fast_i && min_tick_i
         && min_cnt == 8'(rtcoc_pkg::FAST_PERIOD - 8'h01) && offset_i != 8'h00)
        |=> (state == rtcoc_pkg::RTCOC_APPLY)) else $error("fast start missed");
    AST_NEG_SUB: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (state == rtcoc_pkg::RTCOC_IDLE && next_state == rtcoc_pkg::RTCOC_APPLY && offset_i[7])
        |=> (neg && remain == mag($past(offset_i)))) else $error("bad magnitude");
endmodule

// File: design/rtcoc_top.sv
/*
 * Oscillator configuration register with dual-controller access and correction scheduling.
 * Assumes both controllers present decoded byte writes on clock_i and time ticks are local.
 */
`timescale 1ns/1ps
module rtcoc_top (
    input  wire logic                  clock_i,
    input  wire logic                  rst_b_i,
    input  wire rtcoc_pkg::rtcoc_wr_t  pri_wr_i,
    input  wire rtcoc_pkg::rtcoc_wr_t  sec_wr_i,
    input  wire logic [7:0]            rd_addr_i,
    input  wire logic                  calib_access_owner_i,
    input  wire logic                  clkout_sel_i,
    input  wire logic                  sec_tick_i,
    input  wire logic                  min_tick_i,
    output logic [7:0]                 rd_data_o,
    output logic                       clkout_o,
    output logic                       low_jitter_en_o,
    output logic [1:0]                 xtal_drive_sel_o,
    output logic [1:0]                 xtal_load_cap_sel_o,
    output logic                       pulse_add_o,
    output logic                       pulse_sub_o,
    output logic                       busy_o
);
    rtcoc_pkg::rtcoc_osc_t osc;
    rtcoc_pkg::rtcoc_osc_t next_osc;
    logic [7:0] offset;
    logic [7:0] next_offset;
    logic [7:0] next_rd;
    rtcoc_pkg::rtcoc_wr_t  wsel;

    // ==========================================================================
    // Register writes; only the owning controller may write.
    always_comb begin
        wsel        = calib_access_owner_i ? pri_wr_i : sec_wr_i;
        next_osc    = osc;
        next_offset = offset;
        if (wsel.wr && wsel.addr == rtcoc_pkg::OSC_CFG_ADDR) begin
            next_osc = rtcoc_pkg::rtcoc_osc_t'(wsel.data & rtcoc_pkg::OSC_CFG_WMASK);
        end
        if (wsel.wr && wsel.addr == rtcoc_pkg::OFFSET_ADDR) begin
            next_offset = wsel.data;
        end
        unique case (rd_addr_i)
            rtcoc_pkg::OSC_CFG_ADDR: next_rd = 8'(osc) & rtcoc_pkg::OSC_CFG_WMASK;
            rtcoc_pkg::OFFSET_ADDR:  next_rd = offset;
            default:                 next_rd = 8'h00;
        endcase
    end

    // ==========================================================================
    // Drive and load fields: 11 aliases 10 for both.
    function automatic logic [1:0] fold(input logic [1:0] f);
        fold = f[1] ? 2'h2 : f;
    endfunction

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            osc                 <= rtcoc_pkg::rtcoc_osc_t'(rtcoc_pkg::OSC_CFG_RESET);
            offset              <= 8'h00;
            rd_data_o           <= 8'h00;
            clkout_o            <= 1'b0;
            low_jitter_en_o     <= 1'b0;
            xtal_drive_sel_o    <= rtcoc_pkg::DRV_NORMAL;
            xtal_load_cap_sel_o <= rtcoc_pkg::CAP_7P0;
        end else begin
            osc                 <= next_osc;
            offset              <= next_offset;
            rd_data_o           <= next_rd;
            clkout_o            <= clkout_sel_i ^ osc.clkout_invert;
            low_jitter_en_o     <= osc.low_jitter_en;
            xtal_drive_sel_o    <= fold(osc.xtal_drive_sel);
            xtal_load_cap_sel_o <= fold(osc.xtal_load_cap_sel);
        end
    end

    rtcoc_pulse_sched u_sched (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .fast_i      (osc.correction_mode_sel),
        .offset_i    (offset),
        .sec_tick_i  (sec_tick_i),
        .min_tick_i  (min_tick_i),
        .pulse_add_o (pulse_add_o),
        .pulse_sub_o (pulse_sub_o),
        .busy_o      (busy_o)
    );

    AST_RSVD_ZERO: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !osc.rsvd) else $error("reserved bit set");
    AST_SEC_BLOCKED: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (calib_access_owner_i && !pri_wr_i.wr) |=> $stable(osc)) else $error("write leaked");
    AST_INVERT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> clkout_o == ($past(clkout_sel_i) ^ $past(osc.clkout_invert)))
        else $error("invert");
    AST_LOAD_FOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        xtal_load_cap_sel_o != 2'h3 && xtal_drive_sel_o != 2'h3) else $error("fold");
endmodule

// File: tb/rtcoc_ctrl_model.sv
/*
 * Model of one register controller: issues one-cycle byte writes.
 * Assumes the block samples writes on the rising edge of clk_i.
 */
`timescale 1ns/1ps
// ==========================================================================
// Controller
module rtcoc_ctrl_model #(
    parameter int GAP = 16
) (
    input  wire logic            clk_i,
    output rtcoc_pkg::rtcoc_wr_t wr_o
);
    initial wr_o = '0;
    // The real software wait is scaled down so that runs stay short.
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_o = '{wr: 1'b1, addr: a, data: d};
        @(negedge clk_i);
        wr_o = '0;
        repeat (GAP) @(negedge clk_i);
    endtask
endmodule

// File: tb/tb_rtcoc_top.sv
/*
 * Self-checking bench for rtcoc_top.
 * Assumes the controller model drives both write ports.
 */
`timescale 1ns/1ps
module tb_rtcoc_top;
    logic                 clock_i = 0, rst_b_i = 0, own = 0, csel = 0;
    logic                 st = 0, mt = 0, ck, lj, pa, ps, bz;
    logic [7:0]           ra = 8'h00, rd;
    logic [1:0]           dr, cp;
    rtcoc_pkg::rtcoc_wr_t pw, sw;
    int                   fails = 0, checked = 0, na = 0, ns = 0;

    rtcoc_top rtcoc_top_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .pri_wr_i(pw),
        .sec_wr_i(sw), .rd_addr_i(ra), .calib_access_owner_i(own), .clkout_sel_i(csel),
        .sec_tick_i(st), .min_tick_i(mt), .rd_data_o(rd), .clkout_o(ck),
        .low_jitter_en_o(lj), .xtal_drive_sel_o(dr), .xtal_load_cap_sel_o(cp),
        .pulse_add_o(pa), .pulse_sub_o(ps), .busy_o(bz));
    rtcoc_ctrl_model pri (.clk_i(clock_i), .wr_o(pw));
    rtcoc_ctrl_model sec (.clk_i(clock_i), .wr_o(sw));

    initial forever #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (pa === 1'b1) na++;
        if (ps === 1'b1) ns++;
    end
    // ==========================================================================
    // Shared tasks
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock_i) ra = a;
        @(negedge clock_i);
        chk("rd_data", e, rd);
    endtask
    task automatic rst();
        @(negedge clock_i) rst_b_i = 0;
        repeat (5) @(negedge clock_i);
        rst_b_i = 1;
    endtask
    task automatic tk(input bit m);
        @(negedge clock_i) if (m) mt = 1; else st = 1;
        @(negedge clock_i) {mt, st} = 2'b00;
        @(negedge clock_i);
    endtask
    task automatic summarize();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================================
    // Scenarios
    task automatic t_access();
        own = 0;
        pri.put(8'h13, 8'h55);
        rdc(8'h13, 8'h00);
        sec.put(8'h13, 8'hFF);
        rdc(8'h13, 8'hDF);
        own = 1;
        sec.put(8'h13, 8'h00);
        rdc(8'h13, 8'hDF);
        pri.put(8'h13, 8'h01);
        rdc(8'h13, 8'h01);
        rdc(8'h20, 8'h00);
    endtask
    task automatic t_fields();
        for (int i = 0; i < 4; i++) begin
            pri.put(8'h13, 8'hB0 | 8'(i << 2) | 8'(i));
            rdc(8'h13, 8'h90 | 8'(i << 2) | 8'(i));
            chk("drive", (i == 3) ? 8'h02 : 8'(i), {6'h00, dr});
            chk("load", (i == 3) ? 8'h02 : 8'(i), {6'h00, cp});
            chk("low_jitter_en", 8'h01, {7'h00, lj});
            for (int c = 0; c < 2; c++) begin
                csel = c[0];
                repeat (2) @(negedge clock_i);
                chk("clkout", {7'h00, ~csel}, {7'h00, ck});
            end
        end
        pri.put(8'h13, 8'h00);
        chk("load", 8'h00, {6'h00, cp});
        chk("clkout", {7'h00, csel}, {7'h00, ck});
        chk("low_jitter_en", 8'h00, {7'h00, lj});
    endtask
    // Fast mode spills 60 pulses a minute; normal mode pulses on every minute tick.
    task automatic t_corr(input logic m, input logic [7:0] off);
        int rem;
        int e;
        int a0;
        int s0;
        rem = off[7] ? 256 - int'(off) : int'(off);
        rst();
        own = 1;
        pri.put(8'h12, off);
        pri.put(8'h13, {1'b0, m, 6'h00});
        a0 = na;
        s0 = ns;
        repeat ((m ? rtcoc_pkg::FAST_PERIOD_MIN : rtcoc_pkg::NORMAL_PERIOD_MIN) - 1) tk(1);
        chk("early", 8'h00, 8'((na - a0) + (ns - s0)));
        tk(1);
        for (int k = 0; k < (m ? 3 : 1); k++) begin
            a0 = na;
            s0 = ns;
            repeat (60) tk(!m);
            e = (rem > 60) ? 60 : rem;
            rem -= e;
            chk("add", off[7] ? 8'h00 : 8'(e), 8'(na - a0));
            chk("sub", off[7] ? 8'(e) : 8'h00, 8'(ns - s0));
            chk("busy", {7'h00, rem > 0}, {7'h00, bz});
            if (m) tk(1);
        end
    endtask
    // ==========================================================================
    // Main sequence and watchdog
    initial begin
        rst();
        chk("reset", 8'h00, {lj, dr, cp, pa, ps, bz});
        rdc(8'h13, 8'h00);
        t_access();
        t_fields();
        t_corr(1'b1, 8'h3E);
        t_corr(1'b1, 8'h80);
        t_corr(1'b0, 8'h05);
        summarize();
    end
    initial begin
        #200000;
        fails++;
        summarize();
    end
endmodule
